// ---- dtd_event_src.sv ----
/*
  Far-side event source: makes bursts of falling edges on one event line.
  Assumes the bench pulses go for one cycle while busy is low.
*/
`default_nettype none
module dtd_event_src (
  input wire logic core_clk, // Bench clock
  input wire logic go, // One-cycle start pulse
  input wire logic [7:0] edges, // Falling edges in the burst
  input wire logic [3:0] hold, // Cycles per level, two or more
  output logic pin, // Event line, idles high like a pulled-up wire
  output logic busy // Burst in progress
);
  logic [7:0] left; // Falling edges still owed
  logic [3:0] ph; // Cycles spent at the present level
  initial begin
    pin = 1'b1;
    left = 8'h00;
    ph = 4'h0;
  end
  assign busy = (left != 8'h00);
  // Levels last hold cycles; a slow hold tests the synchroniser at ease
  always @(posedge core_clk) begin
    if (go) begin
      left <= edges;
      ph <= 4'h1;
    end else if (busy) begin
      ph <= (ph >= hold) ? 4'h1 : ph + 4'h1;
      if (ph >= hold) begin
        pin <= ~pin;
        // Burst ends high, so the line rests in its idle state
        if (!pin) left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dtd_pkg.sv ----
/*
  Types for the dual 8-bit timer/divider: channel control word and
  per-channel status carrier.
  Assumes dtd_regs.svh sits in the same folder.
*/
`default_nettype none
package dtd_pkg;
  // Channel control word, fields as laid out in the control register
  typedef struct packed {
    logic ff_init;   // Flip-flop initial value
    logic [2:0] clk_sel; // Clock source select
    logic run;       // Run control
    logic [2:0] mode;    // Mode select
  } dtd_ctrl_t;

  // Per-channel observable state
  typedef struct packed {
    logic [7:0] count; // Up-counter value
    logic ff;          // Timer flip-flop
  } dtd_stat_t;

  // Channel operating class after decode
  typedef enum logic [1:0] {
    DTD_OP_IDLE = 2'b00,
    DTD_OP_TIMER = 2'b01,
    DTD_OP_DIV = 2'b10
  } dtd_op_t;
endpackage
`default_nettype wire

// ---- dtd_regs.svh ----
/*
  Constants for the dual 8-bit timer/divider: control field positions,
  mode and clock-select codes, reset values and prescaler tap positions.
  Assumes inclusion by the design file and the bench only.
*/
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH

// Control register field positions and reset values
`define DTD_CR_MODE_LSB 0
`define DTD_CR_RUN_BIT 3
`define DTD_CR_CLK_LSB 4
`define DTD_CR_FF_BIT 7
`define DTD_CR_RESET 8'h00
`define DTD_CMP_RESET 8'h01

// Mode select codes
`define DTD_MODE_TIMER 3'h0
`define DTD_MODE_DIV 3'h1
`define DTD_MODE_PWM8 3'h2
`define DTD_MODE_RSVD 3'h3
`define DTD_MODE_PWM16 3'h6

// Clock select codes
`define DTD_CK_DIV11 3'h0
`define DTD_CK_DIV7 3'h1
`define DTD_CK_DIV5 3'h2
`define DTD_CK_DIV3 3'h3
`define DTD_CK_LOW 3'h4
`define DTD_CK_DIV1 3'h5
`define DTD_CK_FULL 3'h6
`define DTD_CK_PIN 3'h7

// Prescaler tap indices for the high- and low-frequency clock divider chains
`define DTD_TAP_11 10
`define DTD_TAP_7 6
`define DTD_TAP_5 4
`define DTD_TAP_3 2
`define DTD_TAP_1 0
`define DTD_LTAP_3 2

`endif

// ---- dtd_timer.sv ----
/*
  Dual 8-bit timer/event counter/divider. Each channel has an up-counter,
  a compare value, a timer flip-flop and a match pulse. Control words and
  compare values arrive as plain ports; control writes are marked by strobes.
  Assumes all inputs but event_in_pin are synchronous to core_clk and that the high- and
  low-frequency clock ticks arrive as one-cycle enables.
*/
// Behaviour
// - Cascaded modes take lower channel clock select
// - Slow mode: only low/8, low clock or pins
// - Timer counts clock, match pulses and clears
// - Compare value used immediately, unbuffered
// - Event mode counts falling pin edges
// - Divider match toggles flip-flop, clears, pulses
// - Divider pin is inverse of flip-flop
// - Init bit presets flip-flop; reset clears it
// - Stop holds pin; rewrite init afterwards
// - Control bit 3 runs or stops
// - Control bit 7 sets flip-flop value
// - Clock select maps eight sources
// - Stop write clears the counter
// - Mode 001 divider, 1xx cascaded timer, 011 reserved
`include "dtd_regs.svh"
`default_nettype none
module dtd_timer #(
  parameter int CHANNELS = 2 // Two cascadable channels
) (
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic hf_tick, // High-frequency clock enable pulse
  input wire logic lf_tick, // Low-frequency clock enable pulse
  input wire logic slow_mode, // Slow or sleep power mode
  input wire logic divider_tap_select, // Use low/8 for code 000
  input wire dtd_pkg::dtd_ctrl_t channel_control_reg [CHANNELS], // Control words
  input wire logic [CHANNELS-1:0] ctrl_wr, // Control write strobes
  input wire logic [7:0] compare_value_reg [CHANNELS], // Compare values
  input wire logic [CHANNELS-1:0] event_in_pin, // External event inputs
  output logic [CHANNELS-1:0] match_irq, // Match pulses
  output logic [CHANNELS-1:0] divider_out_pin, // Inverted flip-flop
  output dtd_pkg::dtd_stat_t status [CHANNELS] // Counter and flip-flop
);
  // Prescaler chains: each bit toggles, a tap ticks as its bit falls
  logic [10:0] hf_div;
  logic [2:0] lf_div;
  logic [10:0] hf_rise;
  logic [2:0] lf_rise;

  // Free-running chains; a tap fires when its bit and all lower bits are ones
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hf_div <= 11'h000;
      lf_div <= 3'h0;
    end else if (clk_en) begin
      if (hf_tick) hf_div <= hf_div + 11'h001;
      if (lf_tick) lf_div <= lf_div + 3'h1;
    end
  end

  // Tap n fires once every 2^(n+1) source ticks
  for (genvar b = 0; b < 11; b++) begin : g_hfrise
    assign hf_rise[b] = hf_tick && (&hf_div[b:0]);
  end
  for (genvar b = 0; b < 3; b++) begin : g_lfrise
    assign lf_rise[b] = lf_tick && (&lf_div[b:0]);
  end

  // Source-clock decode shared by both channels
  function automatic logic src_tick(input logic [2:0] sel, input logic pin_fall);
    logic t;
    t = 1'b0;
    if (slow_mode) begin
      // Only the low/8 tap, low clock or pins remain usable
      unique case (sel)
        `DTD_CK_DIV11: t = lf_rise[`DTD_LTAP_3];
        `DTD_CK_LOW: t = lf_tick;
        `DTD_CK_PIN: t = pin_fall;
        default: t = 1'b0;
      endcase
    end else begin
      unique case (sel)
        `DTD_CK_DIV11: t = divider_tap_select ? lf_rise[`DTD_LTAP_3] : hf_rise[`DTD_TAP_11];
        `DTD_CK_DIV7: t = hf_rise[`DTD_TAP_7];
        `DTD_CK_DIV5: t = hf_rise[`DTD_TAP_5];
        `DTD_CK_DIV3: t = hf_rise[`DTD_TAP_3];
        `DTD_CK_LOW: t = lf_tick;
        `DTD_CK_DIV1: t = hf_rise[`DTD_TAP_1];
        `DTD_CK_FULL: t = hf_tick;
        `DTD_CK_PIN: t = pin_fall;
      endcase
    end
    return t;
  endfunction

  // Mode decode; 8-bit PWM and reserved codes leave the channel idle
  function automatic dtd_pkg::dtd_op_t op_of(input logic [2:0] m);
    dtd_pkg::dtd_op_t o;
    o = dtd_pkg::DTD_OP_IDLE;
    if (m == `DTD_MODE_TIMER) o = dtd_pkg::DTD_OP_TIMER;
    else if (m == `DTD_MODE_DIV) o = dtd_pkg::DTD_OP_DIV;
    else if (m[2]) o = dtd_pkg::DTD_OP_TIMER; // Cascaded: counts as timer per byte
    return o;
  endfunction

  // Pin synchronisers: two flops, then a third sample for the edge
  logic [CHANNELS-1:0] ev_s1, ev_s2, ev_s3;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev_s1 <= '1;
      ev_s2 <= '1;
      ev_s3 <= '1;
    end else if (clk_en) begin
      ev_s1 <= event_in_pin;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end
  wire logic [CHANNELS-1:0] ev_fall = ev_s3 & ~ev_s2;

  logic [7:0] cnt [CHANNELS];
  logic [CHANNELS-1:0] ff;
  logic [CHANNELS-1:0] tick;
  logic [CHANNELS-1:0] hit;
  logic [CHANNELS-1:0] ff_run_q; // Run level seen one edge ago

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    dtd_pkg::dtd_ctrl_t cr;
    dtd_pkg::dtd_op_t op;
    logic [2:0] sel;
    assign cr = channel_control_reg[c];
    assign op = op_of(cr.mode);
    // Cascaded modes draw the clock from the lower channel's select
    assign sel = cr.mode[2] ? channel_control_reg[0].clk_sel : cr.clk_sel;
    assign tick[c] = cr.run && (op != dtd_pkg::DTD_OP_IDLE) && src_tick(sel, ev_fall[c]);
    // Compare taken live from the port: no shadow copy
    assign hit[c] = tick[c] && (cnt[c] + 8'h01 == compare_value_reg[c]);

    // Counter: counts ticks, clears on match and on stop
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cnt[c] <= 8'h00;
      end else if (clk_en) begin
        if (!cr.run) cnt[c] <= 8'h00;
        else if (hit[c]) cnt[c] <= 8'h00;
        else if (tick[c]) cnt[c] <= cnt[c] + 8'h01;
      end
    end

    // Flip-flop: preset while stopped, toggles on divider match
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        ff[c] <= 1'b0;
      end else if (clk_en) begin
        // A stop write keeps the level; only a later write while stopped presets it
        if (ctrl_wr[c] && !cr.run && !ff_run_q[c]) ff[c] <= cr.ff_init;
        else if (ctrl_wr[c] && cr.run && !ff_run_q[c]) ff[c] <= cr.ff_init;
        else if (hit[c] && op == dtd_pkg::DTD_OP_DIV) ff[c] <= ~ff[c];
      end
    end

    // Match pulse registered, coincides with counter at zero
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        match_irq[c] <= 1'b0;
      end else if (clk_en) begin
        match_irq[c] <= hit[c];
      end
    end

    assign divider_out_pin[c] = ~ff[c];
    assign status[c] = '{count: cnt[c], ff: ff[c]};
  end

  // Previous run state, to tell a stop write from a write while stopped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ff_run_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < CHANNELS; i++) ff_run_q[i] <= channel_control_reg[i].run;
    end
  end

  // Checks
  a_match_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && hit[0] |=> match_irq[0] && cnt[0] == 8'h00)
    else $error("match pulse without counter clear");
  a_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !channel_control_reg[0].run |=> cnt[0] == 8'h00)
    else $error("counter not cleared on stop");
  a_div_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && hit[1] && !ctrl_wr[1] && channel_control_reg[1].mode == `DTD_MODE_DIV
    |=> ff[1] != $past(ff[1]))
    else $error("divider flip-flop did not toggle");
  a_pin_inverse: assert property (@(posedge core_clk) disable iff (!rst_n)
    divider_out_pin == ~ff)
    else $error("divider pin not inverse of flip-flop");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ff_run_q[0] && !channel_control_reg[0].run |=> $stable(ff[0]))
    else $error("pin level changed on stop");
  a_preset_ff: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ctrl_wr[0] && !ff_run_q[0] |=> ff[0] == $past(channel_control_reg[0].ff_init))
    else $error("preset not taken");
  a_event_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ev_fall[0] && channel_control_reg[0].run && !hit[0]
    && channel_control_reg[0].clk_sel == `DTD_CK_PIN && channel_control_reg[0].mode == 3'h0
    |=> cnt[0] == $past(cnt[0]) + 8'h01)
    else $error("falling edge not counted");
  a_slow_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    slow_mode && channel_control_reg[0].clk_sel == `DTD_CK_DIV7 && !channel_control_reg[0].mode[2]
    |-> !tick[0])
    else $error("fast source used in slow mode");
  a_cascade_clk: assert property (@(posedge core_clk) disable iff (!rst_n)
    channel_control_reg[1].mode[2] && channel_control_reg[1].run
    && channel_control_reg[0].clk_sel == `DTD_CK_PIN |-> !tick[1] || ev_fall[1])
    else $error("cascade ignored lower select");
  c_match: cover property (@(posedge core_clk) match_irq[0]);
  c_div_wave: cover property (@(posedge core_clk) ff[1] ##1 !ff[1]);
  c_event: cover property (@(posedge core_clk) ev_fall[0] && tick[0]);
endmodule
`default_nettype wire

// ---- dtd_timer_tb.sv ----
/*
  Self-checking bench for the dual timer: timer, divider, event and
  refused modes on random channels and compare values.
  Assumes dtd_event_src drives the event lines.
*/
`include "dtd_regs.svh"
`default_nettype none
module dtd_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, slow_mode = 0; // Clock, reset, power mode
  logic [1:0] ctrl_wr = 0, ev_go = 0; // Strobes
  wire logic [1:0] ev_pin, ev_busy, irq, dout; // Pins driven by the models and the design
  dtd_pkg::dtd_ctrl_t ctrl [2]; // Control words
  logic [7:0] cmp [2], ev_n = 8'h01, c, snap; // Compare values, burst length
  logic [3:0] ev_hold = 4'h2; // Level width of the source
  dtd_pkg::dtd_stat_t stat [2]; // Counter and flip-flop
  int mismatches = 0, cmp_count = 0, cycles = 0, seed = 32'h974b, ch, n, hits;
  logic ff0; // Flip-flop preset value
  dtd_timer #(.CHANNELS(2)) i_dtd_timer (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(1'b1), .hf_tick(1'b1), .lf_tick(1'b0), .slow_mode(slow_mode),
    .divider_tap_select(1'b0), .channel_control_reg(ctrl), .ctrl_wr(ctrl_wr),
    .compare_value_reg(cmp), .event_in_pin(ev_pin), .match_irq(irq),
    .divider_out_pin(dout), .status(stat));
  for (genvar g = 0; g < 2; g++) begin : g_src
    dtd_event_src i_dtd_event_src (.core_clk(core_clk), .go(ev_go[g]), .edges(ev_n),
      .hold(ev_hold), .pin(ev_pin[g]), .busy(ev_busy[g]));
  end
  always #10 core_clk = ~core_clk;
  // Hang guard, well above the longest scenario
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One control write, then an idle edge so the strobe is seen low
  task automatic wr(logic [2:0] mode, logic [2:0] ck, logic run, logic ff);
    ctrl[ch] <= '{ff, ck, run, mode};
    ctrl_wr[ch] <= 1'b1;
    @(posedge core_clk);
    ctrl_wr[ch] <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // Edges until the match pulse shows, bounded
  task automatic gap();
    n = 0;
    while (irq[ch] !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // Wait k edges, counting match pulses
  task automatic idle(int k);
    hits = 0;
    repeat (k) begin
      @(posedge core_clk);
      #1;
      if (irq[ch] === 1'b1) hits++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    foreach (ctrl[i]) ctrl[i] = '0;
    foreach (cmp[i]) cmp[i] = 8'h01;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check("pins after reset", {6'h00, dout}, 8'h03);
    check("irq after reset", {6'h00, irq}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      ch = $random(seed) & 1;
      c = (k == 0) ? 8'h01 : 8'h02 + 8'($random(seed) & 8'h1f);
      ff0 = 1'($random(seed));
      cmp[ch] <= c;
      // Timer on the /8 tap, a legal timer source: eight cycles per count
      wr(`DTD_MODE_TIMER, `DTD_CK_DIV3, 1'b1, 1'b0);
      gap();
      check("count at match", stat[ch].count, 8'h00);
      @(posedge core_clk);
      #1;
      gap();
      check("timer period", 8'((n + 1) >> 3), c);
      check("timer phase", 8'((n + 1) & 7), 8'h00);
      wr(`DTD_MODE_TIMER, `DTD_CK_DIV3, 1'b0, 1'b0);
      check("count after stop", stat[ch].count, 8'h00);
      // Divider: preset while stopped so no early match can hide it
      wr(`DTD_MODE_DIV, `DTD_CK_DIV3, 1'b0, ff0);
      check("preset pin", {7'h00, dout[ch]}, {7'h00, ~ff0});
      // The port latch sits outside this block; the pin is watched directly
      wr(`DTD_MODE_DIV, `DTD_CK_DIV3, 1'b1, ff0);
      gap();
      check("ff after match", {7'h00, stat[ch].ff}, {7'h00, ~ff0});
      check("pin inverse", {7'h00, dout[ch]}, {7'h00, ff0});
      @(posedge core_clk);
      #1;
      gap();
      check("half period", 8'((n + 1) >> 3), c);
      check("half phase", 8'((n + 1) & 7), 8'h00);
      wr(`DTD_MODE_DIV, `DTD_CK_DIV3, 1'b0, ff0);
      snap = {7'h00, dout[ch]};
      idle(8 * c + 8);
      check("pin held on stop", {7'h00, dout[ch]}, snap);
      wr(`DTD_MODE_DIV, `DTD_CK_DIV3, 1'b0, 1'b0);
      check("pin high by clear", {7'h00, dout[ch]}, 8'h01);
      wr(`DTD_MODE_DIV, `DTD_CK_DIV3, 1'b0, 1'b1);
      check("pin low by set", {7'h00, dout[ch]}, 8'h00);
      // Event counting: count edges, then one match at the compare value
      ev_n <= 8'h01 + 8'($random(seed) & 8'h0f);
      ev_hold <= 4'h2 + 4'($random(seed) & 3);
      cmp[ch] <= 8'hff;
      wr(`DTD_MODE_TIMER, `DTD_CK_PIN, 1'b1, 1'b0);
      ev_go[ch] <= 1'b1;
      @(posedge core_clk);
      ev_go[ch] <= 1'b0;
      idle(200);
      check("edges counted", stat[ch].count, ev_n);
      wr(`DTD_MODE_TIMER, `DTD_CK_PIN, 1'b0, 1'b0);
      cmp[ch] <= ev_n;
      wr(`DTD_MODE_TIMER, `DTD_CK_PIN, 1'b1, 1'b0);
      ev_go[ch] <= 1'b1;
      @(posedge core_clk);
      ev_go[ch] <= 1'b0;
      idle(200);
      check("event matches", 8'(hits), 8'h01);
      check("event clear", stat[ch].count, 8'h00);
      wr(`DTD_MODE_TIMER, `DTD_CK_PIN, 1'b0, 1'b0);
      // Refused settings never count: reserved mode, slow-mode fast tap
      slow_mode <= k[0];
      wr(k[0] ? `DTD_MODE_TIMER : `DTD_MODE_RSVD, k[0] ? `DTD_CK_DIV7 : `DTD_CK_FULL, 1'b1,
        1'b0);
      idle(40);
      check("refused count", stat[ch].count, 8'h00);
      wr(k[0] ? `DTD_MODE_TIMER : `DTD_MODE_RSVD, k[0] ? `DTD_CK_DIV7 : `DTD_CK_FULL, 1'b0,
        1'b0);
      slow_mode <= 1'b0;
    end
    conclude();
  end
endmodule
`default_nettype wire
